// ==== include/psw_pkg.sv ====
// package for the program space data window bridge
package psw_pkg;
  localparam int DATA_AW = 16;
  localparam int PAGE_W = 8;
  localparam int LOW_W = 15;
  localparam int PROG_AW = PAGE_W + LOW_W;
  localparam int PWORD_W = 24;
  localparam int DWORD_W = 16;
  localparam int WIN_BIT = 15;
  localparam logic [DATA_AW-1:0] WIN_BASE = 16'h8000;
  localparam logic [1:0] STALL_NONE = 2'h0;
  localparam logic [1:0] STALL_ONE = 2'h1;
  localparam logic [1:0] STALL_TWO = 2'h2;
  // register map (byte addresses)
  localparam logic [3:0] REG_PAGE = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    REP_NONE,
    REP_EDGE,
    REP_MID
  } psw_rep_t;

  typedef struct packed {
    logic               valid;
    logic [DATA_AW-1:0] addr;
    logic               wordMove;
    psw_rep_t           repPhase;
  } psw_req_t;
endpackage

// ==== hdl/psw_bridge.sv ====
// program space data window bridge with axi4-lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module psw_bridge
  import psw_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // core data read request
  input  wire psw_req_t             coreReq,
  input  wire logic                 tableBusy,
  output logic                      toProgram,
  output logic                      toData,
  output logic [1:0]                extraCycles,
  output logic [DATA_AW-1:0]        readData,
  output logic                      readValid,
  // program memory fetch
  output logic                      progReq,
  output logic [PROG_AW-1:0]        progAddr,
  input  wire logic [PWORD_W-1:0]   progData,
  input  wire logic                 progValid,
  // axi4-lite slave
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  logic [PAGE_W-1:0] programPageSelect;
  logic              windowEnable;
  logic              hit;
  logic              busy;
  logic [31:0]       hitCount;
  logic              awHeld;
  logic              wHeld;
  logic [3:0]        awAddr;
  logic [31:0]       wData;
  logic [3:0]        wStrb;

  // refuse package widths the address and data paths cannot serve
  if (PROG_AW != PAGE_W + LOW_W || WIN_BIT != LOW_W) begin : g_bad_addr
    $error("window address widths do not tile");
  end
  if (DWORD_W > PWORD_W || DWORD_W != DATA_AW) begin : g_bad_data
    $error("returned data width does not fit");
  end

  // window decode, suspended under table ops
  always_comb begin
    hit = coreReq.valid && coreReq.addr[WIN_BIT] && windowEnable
          && !tableBusy;
  end

  assign toProgram = hit;
  assign toData = coreReq.valid && !hit;

  // stall accounting
  always_comb begin
    extraCycles = STALL_NONE;
    if (hit) begin
      case (coreReq.repPhase)
        REP_NONE: extraCycles = coreReq.wordMove ? STALL_ONE
                                                 : STALL_TWO;
        REP_EDGE: extraCycles = STALL_TWO;
        REP_MID:  extraCycles = STALL_NONE;
        default:  extraCycles = STALL_NONE;
      endcase
    end
  end

  // fetch launch; one outstanding fetch at a time
  always_ff @(posedge core_clk) begin
    if (rst) begin
      progReq  <= 1'b0;
      progAddr <= '0;
      busy     <= 1'b0;
    end else if (!busy && hit) begin
      progReq  <= 1'b1;
      progAddr <= {programPageSelect, coreReq.addr[LOW_W-1:0]};
      busy     <= 1'b1;
    end else begin
      progReq <= 1'b0;
      if (progValid) begin
        busy <= 1'b0;
      end
    end
  end

  // returned word: upper byte dropped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readData  <= '0;
      readValid <= 1'b0;
    end else begin
      readValid <= busy && progValid;
      if (busy && progValid) begin
        readData <= progData[DWORD_W-1:0];
      end
    end
  end

  // status: count of window reads served
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hitCount <= '0;
    end else if (busy && progValid) begin
      hitCount <= hitCount + 32'h1;
    end
  end

  // write channel capture, either order
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (awHeld && wHeld) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wHeld <= 1'b0;
      wData <= '0;
      wStrb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata;
      wStrb <= s_axi_wstrb;
    end else if (awHeld && wHeld) begin
      wHeld <= 1'b0;
    end
  end

  // register update and write response
  always_ff @(posedge core_clk) begin
    if (rst) begin
      programPageSelect <= PAGE_RST;
      windowEnable      <= 1'b0;
      s_axi_bvalid      <= 1'b0;
      s_axi_bresp       <= RESP_OK;
    end else if (awHeld && wHeld) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OK;
      if (awAddr == REG_PAGE) begin
        if (wStrb[0]) begin
          programPageSelect <= wData[PAGE_W-1:0];
        end
      end else if (awAddr == REG_CTRL) begin
        if (wStrb[0]) begin
          windowEnable <= wData[CTRL_EN_BIT];
        end
      end else if (awAddr == REG_STAT) begin
        s_axi_bresp <= RESP_OK;
      end else begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OK;
      if (s_axi_araddr == REG_PAGE) begin
        s_axi_rdata <= 32'(programPageSelect);
      end else if (s_axi_araddr == REG_CTRL) begin
        s_axi_rdata              <= '0;
        s_axi_rdata[CTRL_EN_BIT] <= windowEnable;
      end else if (s_axi_araddr == REG_STAT) begin
        s_axi_rdata <= hitCount;
      end else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== tb/psw_checker.sv ====
// window bridge port assertions
`timescale 1ns/1ps
module psw_checker
  import psw_pkg::*;
(
  // clock, reset, core side
  input wire logic       core_clk, rst, toProgram, readValid,
  input wire logic       tableBusy, toData,
  input wire psw_req_t   coreReq,
  input wire logic [1:0] extraCycles,
  input wire logic [15:0] readData,
  // program side
  input wire logic        progReq, progValid,
  input wire logic [22:0] progAddr,
  input wire logic [23:0] progData
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire [1:0] ph = coreReq.repPhase;
  wire out = toProgram && ph == REP_NONE;
  sequence served;
    ##1 readValid;
  endsequence
  a_win_gate: assert property (toProgram |-> coreReq.valid
    && coreReq.addr[15]) else $error("bad gate");
  a_plain_data: assert property (coreReq.valid && !coreReq.addr[15]
    |-> !toProgram && extraCycles == 0) else $error("bad plain");
  a_move_one: assert property (out && coreReq.wordMove
    |-> extraCycles == 1) else $error("bad move");
  a_other_two: assert property (out && !coreReq.wordMove
    |-> extraCycles == 2) else $error("bad other");
  a_rep_edge: assert property (toProgram && ph == REP_EDGE
    |-> extraCycles == 2) else $error("bad edge");
  a_rep_mid: assert property (toProgram && ph == REP_MID
    |-> extraCycles == 0) else $error("bad mid");
  a_fetch_addr: assert property (progReq |-> progAddr[14:0]
    == $past(coreReq.addr[14:0])) else $error("bad addr");
  a_fetch_done: assert property (progValid |-> served)
    else $error("no answer");
  a_table_hold: assert property (tableBusy |-> !toProgram)
    else $error("window open in table op");
  a_one_side: assert property (coreReq.valid |-> toData != toProgram)
    else $error("bad side");
  a_low_half: assert property (readValid
    |-> readData == $past(progData[15:0])) else $error("bad data");
endmodule
bind psw_bridge psw_checker psw_checker_i (.*);

// ==== tb/psw_prog_mem.sv ====
// program memory model, lag taken from address bits
`timescale 1ns/1ps
module psw_prog_mem
  import psw_pkg::*;
(
  // fetch port
  input  wire logic               core_clk, progReq,
  input  wire logic [PROG_AW-1:0] progAddr,
  output logic [PWORD_W-1:0]      progData,
  output logic                    progValid
);
  logic [1:0] cnt = 2'h0;
  logic       busy = 1'b0;
  // top byte set so a kept upper byte shows up
  wire [23:0] word = {8'hff, progAddr[15:0] ^ 16'hc3a5};
  always @(posedge core_clk) begin
    progValid <= busy && cnt == 2'h0;
    progData <= busy && cnt == 2'h0 ? word : ~word;
    // an unknown request while reset settles is no fetch
    if (progReq === 1'b1) begin
      cnt <= progAddr[1:0];
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 2'h1;
      busy <= cnt != 2'h0;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// bench for the window bridge
`timescale 1ns/1ps
module testbench
  import psw_pkg::*;
;
  logic core_clk = 1'b0, rst = 1'b1, tableBusy = 1'b0, en = 1'b0;
  logic toProgram, toData, readValid, progReq, progValid, s_axi_awvalid;
  logic s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] extraCycles, s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [15:0] readData;
  logic [22:0] progAddr;
  logic [23:0] progData;
  logic [7:0] page = 8'hff;
  psw_req_t coreReq = '0;
  int nFail = 0, checksDone = 0;
  psw_bridge psw_bridge_i (.*);
  psw_prog_mem psw_prog_mem_i (.*);
  initial forever #20 core_clk = ~core_clk;
  initial #40000 wrapUp(1);
  task automatic chk(input string n, input logic [31:0] e, g);
    checksDone++;
    if (g !== e) begin
      nFail++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wrapUp(input int late);
    nFail += late;
    if (nFail == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic [2:0] t;
    logic done;
    @(posedge core_clk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready}
      <= {w, w, w, !w, !w};
    do begin
      @(negedge core_clk);
      t = {s_axi_awready, s_axi_wready, s_axi_arready};
      done = s_axi_bvalid | s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge core_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid}
        <= {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} & ~t;
    end while (!done);
    {s_axi_bready, s_axi_rready} <= 2'h0;
  endtask
  task automatic acc(input logic [15:0] a, input logic m, input psw_rep_t p,
                     input logic [1:0] e);
    logic hit;
    int n = 0;
    @(posedge core_clk);
    hit = a[15] && en && !tableBusy;
    coreReq <= '{1'b1, a, m, p};
    @(negedge core_clk);
    chk("route", hit, toProgram);
    chk("extra", hit ? e : STALL_NONE, extraCycles);
    chk("plain", !hit, toData);
    // hold the request only until the fetch answers, so no refetch
    while (hit && !progValid && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    coreReq <= '0;
    if (hit) begin
      @(negedge core_clk);
      chk("data", {page[0], a[14:0]} ^ 16'hc3a5, readData);
      chk("valid", 1'b1, readValid);
      chk("addr", {page, a[14:0]}, progAddr);
    end
  endtask
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    acc(16'h9234, 1'b1, REP_NONE, STALL_ONE);
    bus(1'b1, REG_CTRL, 32'h4);
    chk("wresp", RESP_OK, rsp);
    en = 1'b1;
    bus(1'b1, REG_PAGE, 32'hff);
    bus(1'b0, REG_PAGE, 32'h0);
    chk("page", 32'hff, rd);
    bus(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 32'h4, rd);
    acc(16'h8000, 1'b1, REP_NONE, STALL_ONE);
    acc(16'hfffd, 1'b0, REP_NONE, STALL_TWO);
    acc(16'h8002, 1'b0, REP_EDGE, STALL_TWO);
    acc(16'hc123, 1'b1, REP_MID, STALL_NONE);
    acc(16'h7fff, 1'b0, REP_EDGE, STALL_TWO);
    tableBusy <= 1'b1;
    acc(16'ha5a5, 1'b1, REP_NONE, STALL_ONE);
    tableBusy <= 1'b0;
    acc(16'ha5a6, 1'b1, REP_NONE, STALL_ONE);
    bus(1'b1, REG_PAGE, 32'h3c);
    page = 8'h3c;
    acc(16'hb00e, 1'b0, REP_NONE, STALL_TWO);
    bus(1'b0, REG_STAT, 32'h0);
    chk("served", 32'h6, rd);
    bus(1'b0, 4'hc, 32'h0);
    chk("resp", RESP_SLVERR, rsp);
    bus(1'b1, 4'hc, 32'h0);
    chk("wresp bad", RESP_SLVERR, rsp);
    // mid-run reset must drop page and enable
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    en = 1'b0;
    page = PAGE_RST;
    bus(1'b0, REG_PAGE, 32'h0);
    chk("page rst", 32'(PAGE_RST), rd);
    acc(16'h8000, 1'b1, REP_NONE, STALL_ONE);
    wrapUp(0);
  end
endmodule
